// file: ittt_host.sv
`timescale 1ns/100ps
// Host side of the register port
module ittt_host (
    // Clock
    input wire logic i_clk,
    // Register port
    output logic o_wr_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial begin
        o_wr_en = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    // Data turned over after the strobe so a late sample shows up
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr_en <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_wdata <= ~d;
    endtask
    task automatic point(input logic [7:0] a);
        @(posedge i_clk);
        o_addr <= a;
    endtask
endmodule

// file: ittt_map.svh
`ifndef ITTT_MAP_SVH
`define ITTT_MAP_SVH
// What this block does
// - On thermistor trip, bit 5 picks standby (0, default) or minimum torch current (1).
// - Trip voltage from bits 4:2; 200 mV plus 100 mV per code, default 600 mV.
// - Bias current from bits 1:0: 25/50/75/100 uA, default 75 uA.
// - Indicator ramp up/down codes give 16 ms doubling to 2.048 s, default 000.
// - Pulse hold time from four-bit field, 0 default, tabulated steps to 480 ms.
// - Blank multiplier is upper nibble of blink register, 0 to 15, default 0.
// - Period count is low three bits, 0 to 7, default 0; upper bits reserved.
// - One period equals ramp up plus ramp down plus twice the hold time.
// - Active interval equals period length times period count.
// - Blank interval equals active interval times blank multiplier.
// - Torch ramp up bits 5:3, ramp down bits 2:0, 16 ms doubling, default 000.
// - Indicator mode bit picks internal PWM (default) or external steady-light pin.
// - Thermistor mode bit: monitor only reports; normal applies reduction or shutdown.
`define ITTT_ADDR_THERM 8'h02
`define ITTT_ADDR_IRAMP 8'h03
`define ITTT_ADDR_BLINK 8'h04
`define ITTT_ADDR_PCNT 8'h05
`define ITTT_ADDR_TRAMP 8'h06
`define ITTT_RST_THERM 8'h12
`define ITTT_RST_ZERO 8'h00
`define ITTT_CLK_HZ 20000000
`define ITTT_TICK_US 1000
`define ITTT_TICK_CYC ((`ITTT_CLK_HZ / 1000000) * `ITTT_TICK_US)
`define ITTT_RAMP_BASE_MS 16
`define ITTT_TRIP_BASE_MV 200
`define ITTT_TRIP_STEP_MV 100
`define ITTT_BIAS_STEP_UA 25
`endif

// file: ittt_pkg.sv
package ittt_pkg;
    typedef enum logic [2:0] {
        ITTT_IDLE = 3'b000,
        ITTT_RISE = 3'b001,
        ITTT_HON = 3'b010,
        ITTT_FALL = 3'b011,
        ITTT_HOFF = 3'b100,
        ITTT_BLANK = 3'b101
    } ittt_phase_t;
    typedef struct packed {
        logic [7:0] therm;
        logic [7:0] iramp;
        logic [7:0] blink;
        logic [7:0] pcnt;
        logic [7:0] tramp;
    } ittt_regs_t;
    typedef struct packed {
        logic standby;
        logic reduce_to_min;
        logic trip_flag;
        logic [9:0] trip_mv;
        logic [6:0] bias_ua;
    } ittt_therm_t;
endpackage

// file: ittt_tick.sv
`timescale 1ns/100ps
`include "ittt_map.svh"
// Millisecond tick divider
module ittt_tick
    import ittt_pkg::*;
#(
    parameter int TICK_CYC = `ITTT_TICK_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    output logic o_tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } ittt_tick_st_t;
    ittt_tick_st_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 16'(TICK_CYC - 1)) begin
            s_d.cnt = 16'h0000;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign o_tick = s_q.tick;
endmodule

// file: ittt_top.sv
`timescale 1ns/100ps
`include "ittt_map.svh"
module ittt_top
    import ittt_pkg::*;
#(
    parameter int TICK_CYC = `ITTT_TICK_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Register port
    input wire logic i_wr_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // Mode and pins
    input wire logic i_ind_enable,
    input wire logic i_ind_external,
    input wire logic i_therm_monitor,
    input wire logic i_steady_pin,
    input wire logic i_therm_trip,
    // Outputs
    output logic o_ind_on,
    output logic [11:0] o_ind_level,
    output logic [11:0] o_torch_rise_ms,
    output logic [11:0] o_torch_fall_ms,
    output logic o_therm_standby,
    output logic o_therm_reduce,
    output logic o_therm_flag,
    output logic [9:0] o_trip_mv,
    output logic [6:0] o_bias_ua
);
    // Ramp codes: 16 ms doubled per code
    function automatic logic [11:0] ramp_ms(input logic [2:0] code);
        ramp_ms = 12'(`ITTT_RAMP_BASE_MS) << code;
    endfunction
    // Hold times follow the printed table, not a pure multiple
    function automatic logic [8:0] pulse_ms(input logic [3:0] code);
        case (code)
            4'h3: pulse_ms = 9'd92;
            4'h6: pulse_ms = 9'd196;
            default: pulse_ms = 9'(code) * 9'd32;
        endcase
    endfunction
    typedef struct packed {
        ittt_regs_t regs;
        ittt_phase_t ph;
        logic [12:0] ms;
        logic [2:0] per;
        logic [3:0] blk;
        logic [11:0] lvl;
        logic on;
        logic [1:0] trp_s;
        logic [1:0] pin_s;
        ittt_therm_t th;
    } ittt_st_t;
    ittt_st_t s_q, s_d;
    logic tick;
    logic [11:0] t_r, t_f, t_p;
    logic trip_sync, pin_sync;
    logic [12:0] t_per;
    ittt_phase_t off_ph;
    logic [2:0] off_per;
    ittt_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .o_tick(tick)
    );
    assign t_r = ramp_ms(s_q.regs.iramp[5:3]);
    assign t_f = ramp_ms(s_q.regs.iramp[2:0]);
    assign t_p = 12'(pulse_ms(s_q.regs.blink[3:0]));
    // period length
    // Thirteen bits: two longest ramps plus two holds overflow a 12-bit count
    assign t_per = 13'(t_r) + 13'(t_f) + (13'(t_p) << 1);
    always_comb begin
        off_per = s_q.per + 3'h1;
        off_ph = ITTT_RISE;
        if (s_q.per >= s_q.regs.pcnt[2:0]) begin
            off_per = 3'h1;
            off_ph = (s_q.regs.blink[7:4] == 4'h0) ? ITTT_RISE : ITTT_BLANK;
        end
    end
    assign trip_sync = s_q.trp_s[1];
    assign pin_sync = s_q.pin_s[1];
    always_comb begin
        s_d = s_q;
        s_d.trp_s = {s_q.trp_s[0], i_therm_trip};
        s_d.pin_s = {s_q.pin_s[0], i_steady_pin};
        if (i_wr_en) begin
            case (i_addr)
                `ITTT_ADDR_THERM: s_d.regs.therm = i_wdata & 8'h3F;
                `ITTT_ADDR_IRAMP: s_d.regs.iramp = i_wdata & 8'h3F;
                `ITTT_ADDR_BLINK: s_d.regs.blink = i_wdata;
                `ITTT_ADDR_PCNT: s_d.regs.pcnt = i_wdata & 8'h07;
                `ITTT_ADDR_TRAMP: s_d.regs.tramp = i_wdata & 8'h3F;
                default: s_d.regs = s_q.regs;
            endcase
        end
        s_d.th.trip_mv = 10'(`ITTT_TRIP_BASE_MV)
            + 10'(s_q.regs.therm[4:2]) * 10'(`ITTT_TRIP_STEP_MV);
        s_d.th.bias_ua = 7'(`ITTT_BIAS_STEP_UA) * (7'(s_q.regs.therm[1:0]) + 7'h01);
        s_d.th.trip_flag = trip_sync;
        s_d.th.standby = trip_sync && !i_therm_monitor && !s_q.regs.therm[5];
        s_d.th.reduce_to_min = trip_sync && !i_therm_monitor && s_q.regs.therm[5];
        if (!i_ind_enable || s_q.regs.pcnt[2:0] == 3'h0) begin
            s_d.ph = ITTT_IDLE;
            s_d.ms = 13'h0000;
            s_d.lvl = 12'h000;
        end else if (tick) begin
            s_d.ms = s_q.ms + 13'h0001;
            case (s_q.ph)
                ITTT_IDLE: begin
                    s_d.ph = ITTT_RISE;
                    s_d.ms = 13'h0000;
                    s_d.per = 3'h1;
                    s_d.blk = 4'h0;
                end
                ITTT_RISE: begin
                    s_d.lvl = 12'(s_q.ms);
                    if (s_q.ms + 13'h0001 >= 13'(t_r)) begin
                        // A zero hold time skips the hold phase altogether
                        s_d.ph = (t_p == 12'h000) ? ITTT_FALL : ITTT_HON;
                        s_d.ms = 13'h0000;
                        s_d.lvl = 12'hFFF;
                    end
                end
                ITTT_HON: begin
                    if (s_q.ms + 13'h0001 >= 13'(t_p)) begin
                        s_d.ph = ITTT_FALL;
                        s_d.ms = 13'h0000;
                    end
                end
                ITTT_FALL: begin
                    s_d.lvl = t_f - 12'(s_q.ms);
                    if (s_q.ms + 13'h0001 >= 13'(t_f)) begin
                        s_d.ph = ITTT_HOFF;
                        s_d.ms = 13'h0000;
                        s_d.lvl = 12'h000;
                        if (t_p == 12'h000) begin
                            s_d.ph = off_ph;
                            s_d.per = off_per;
                        end
                    end
                end
                ITTT_HOFF: begin
                    if (s_q.ms + 13'h0001 >= 13'(t_p)) begin
                        s_d.ms = 13'h0000;
                        s_d.ph = off_ph;
                        s_d.per = off_per;
                    end
                end
                ITTT_BLANK: begin
                    // Blank counts whole periods: active length times multiplier
                    if (s_q.ms + 13'h0001 >= t_per) begin
                        s_d.ms = 13'h0000;
                        if (s_q.per >= s_q.regs.pcnt[2:0]) begin
                            s_d.per = 3'h1;
                            if (s_q.blk + 4'h1 >= s_q.regs.blink[7:4]) begin
                                s_d.blk = 4'h0;
                                s_d.ph = ITTT_RISE;
                            end else begin
                                s_d.blk = s_q.blk + 4'h1;
                            end
                        end else begin
                            s_d.per = s_q.per + 3'h1;
                        end
                    end
                end
                default: s_d.ph = ITTT_IDLE;
            endcase
        end
        if (i_ind_external) begin
            s_d.on = i_ind_enable && pin_sync;
        end else begin
            s_d.on = i_ind_enable && s_d.ph != ITTT_IDLE && s_d.ph != ITTT_BLANK
                && s_d.ph != ITTT_HOFF;
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q <= '0;
            s_q.regs.therm <= `ITTT_RST_THERM;
            s_q.th.trip_mv <= 10'd600;
            s_q.th.bias_ua <= 7'd75;
        end else begin
            s_q <= s_d;
        end
    end
    always_comb begin
        case (i_addr)
            `ITTT_ADDR_THERM: o_rdata = s_q.regs.therm;
            `ITTT_ADDR_IRAMP: o_rdata = s_q.regs.iramp;
            `ITTT_ADDR_BLINK: o_rdata = s_q.regs.blink;
            `ITTT_ADDR_PCNT: o_rdata = s_q.regs.pcnt;
            `ITTT_ADDR_TRAMP: o_rdata = s_q.regs.tramp;
            default: o_rdata = 8'h00;
        endcase
    end
    assign o_ind_on = s_q.on;
    assign o_ind_level = i_ind_external ? {12{s_q.on}} : s_q.lvl;
    assign o_torch_rise_ms = ramp_ms(s_q.regs.tramp[5:3]);
    assign o_torch_fall_ms = ramp_ms(s_q.regs.tramp[2:0]);
    assign o_therm_standby = s_q.th.standby;
    assign o_therm_reduce = s_q.th.reduce_to_min;
    assign o_therm_flag = s_q.th.trip_flag;
    assign o_trip_mv = s_q.th.trip_mv;
    assign o_bias_ua = s_q.th.bias_ua;

    property p_standby;
        @(posedge i_clk) disable iff (i_reset)
        o_therm_standby |-> !$past(s_q.regs.therm[5]) && !o_therm_reduce;
    endproperty
    a_standby: assert property (p_standby) else $error("standby with reduce set");
    property p_trip;
        @(posedge i_clk) disable iff (i_reset)
        ##1 o_trip_mv == 10'd200 + 10'($past(s_q.regs.therm[4:2])) * 10'd100;
    endproperty
    a_trip: assert property (p_trip) else $error("trip voltage wrong");
    property p_bias;
        @(posedge i_clk) disable iff (i_reset)
        ##1 o_bias_ua == 7'd25 * (7'($past(s_q.regs.therm[1:0])) + 7'd1);
    endproperty
    a_bias: assert property (p_bias) else $error("bias wrong");
    property p_pcnt;
        @(posedge i_clk) disable iff (i_reset)
        s_q.regs.pcnt[7:3] == 5'h00;
    endproperty
    a_pcnt: assert property (p_pcnt) else $error("reserved bits set");
    property p_monitor;
        @(posedge i_clk) disable iff (i_reset)
        $past(i_therm_monitor) |-> !o_therm_standby && !o_therm_reduce;
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor acted");
    property p_idle;
        @(posedge i_clk) disable iff (i_reset)
        !i_ind_enable |=> s_q.ph == ITTT_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("pattern ran disabled");
    property p_order;
        @(posedge i_clk) disable iff (i_reset)
        s_q.ph == ITTT_HON && $past(s_q.ph) != ITTT_HON |-> $past(s_q.ph) == ITTT_RISE;
    endproperty
    a_order: assert property (p_order) else $error("hold not after rise");
    property p_ext;
        @(posedge i_clk) disable iff (i_reset)
        i_ind_external && i_ind_enable |=> o_ind_on == $past(pin_sync);
    endproperty
    a_ext: assert property (p_ext) else $error("external pin not followed");
    c_trip: cover property (@(posedge i_clk) o_therm_reduce);
    c_blank: cover property (@(posedge i_clk) s_q.ph == ITTT_BLANK);
    c_fall: cover property (@(posedge i_clk) s_q.ph == ITTT_FALL);
endmodule

// file: test_indicator_thermal_torch_timing.sv
`timescale 1ns/100ps
module test_indicator_thermal_torch_timing;
    import ittt_pkg::*;
    typedef struct {string name; int sel; logic [11:0] exp;} ittt_note_t;
    logic clk, reset, wr_en, ind_enable, ind_external, therm_monitor, steady_pin, therm_trip;
    logic [7:0] addr, wdata, rdata;
    logic ind_on, standby, reduce, flag, chk;
    logic [11:0] ind_level, trise, tfall, meas, hi_len;
    logic [9:0] trip_mv;
    logic [6:0] bias_ua;
    ittt_note_t notes[$];
    ittt_note_t n;
    int n_errors = 0;
    int checked = 0;
    int b, t;
    ittt_host host (.i_clk(clk), .o_wr_en(wr_en), .o_addr(addr), .o_wdata(wdata));
    ittt_top #(.TICK_CYC(4)) dut (
        .i_clk(clk), .i_reset(reset), .i_wr_en(wr_en), .i_addr(addr), .i_wdata(wdata),
        .o_rdata(rdata), .i_ind_enable(ind_enable), .i_ind_external(ind_external),
        .i_therm_monitor(therm_monitor), .i_steady_pin(steady_pin), .i_therm_trip(therm_trip),
        .o_ind_on(ind_on), .o_ind_level(ind_level), .o_torch_rise_ms(trise),
        .o_torch_fall_ms(tfall), .o_therm_standby(standby), .o_therm_reduce(reduce),
        .o_therm_flag(flag), .o_trip_mv(trip_mv), .o_bias_ua(bias_ua));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [11:0] seen(input int sel);
        case (sel)
            0: return {4'h0, rdata};
            1: return {2'h0, trip_mv};
            2: return {5'h00, bias_ua};
            3: return trise;
            4: return tfall;
            5: return {11'h000, standby};
            6: return {11'h000, reduce};
            7: return {11'h000, flag};
            8: return {11'h000, ind_on};
            10: return ind_level;
            11: return hi_len;
            default: return meas;
        endcase
    endfunction
    task automatic check(input string name, input logic [11:0] s, input logic [11:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, e, s);
        end
    endtask
    task automatic expect_out(input string name, input int sel, input logic [11:0] e);
        notes.push_back('{name, sel, e});
        @(posedge clk);
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Oldest note is judged against the outputs once they have settled
    always @(negedge clk) begin
        if (chk) begin
            n = notes.pop_front();
            check(n.name, seen(n.sel), n.exp);
        end
    end
    // Whole run needs well under 20000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        results();
    end
    initial begin
        reset = 1'b1;
        {ind_enable, ind_external, therm_monitor, steady_pin, therm_trip, chk} = 6'h00;
        meas = 12'h000;
        hi_len = 12'h000;
        void'($urandom(32'h90B7918C));
        settle(6);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            host.point(8'h02 + i[7:0]);
            expect_out("reset value", 0, (i == 0) ? 12'h012 : 12'h000);
        end
        expect_out("trip default", 1, 12'd600);
        expect_out("bias default", 2, 12'd75);
        expect_out("torch rise default", 3, 12'd16);
        for (int c = 0; c < 7; c++) begin
            b = $urandom % 4;
            host.write(8'h02, {2'b11, 1'b0, c[2:0], b[1:0]});
            settle(3);
            expect_out("trip mv", 1, 12'd200 + 12'd100 * c[11:0]);
            expect_out("bias ua", 2, 12'd25 * (b[11:0] + 12'd1));
            expect_out("thermal reg", 0, {6'h00, c[2:0], b[1:0]});
        end
        host.write(8'h05, 8'hFF);
        settle(2);
        expect_out("period reg", 0, 12'h007);
        host.write(8'h04, 8'hAB);
        settle(2);
        expect_out("blink reg", 0, 12'h0AB);
        for (int c = 0; c < 8; c++) begin
            host.write(8'h06, {2'b00, c[2:0], 3'd7 - c[2:0]});
            settle(3);
            expect_out("torch rise", 3, 12'd16 << c);
            expect_out("torch fall", 4, 12'd16 << (7 - c));
        end
        host.write(8'h02, 8'h12);
        therm_trip <= 1'b1;
        settle(5);
        expect_out("standby", 5, 12'h001);
        expect_out("flag", 7, 12'h001);
        host.write(8'h02, 8'h32);
        settle(4);
        expect_out("reduce", 6, 12'h001);
        expect_out("no standby", 5, 12'h000);
        therm_monitor <= 1'b1;
        settle(4);
        expect_out("monitor reduce", 6, 12'h000);
        expect_out("monitor flag", 7, 12'h001);
        {therm_trip, therm_monitor} <= 2'b00;
        // Pulse 92 ms, one period, blank x1: rising edges 432 ms apart
        host.write(8'h03, 8'h00);
        host.write(8'h04, 8'h13);
        host.write(8'h05, 8'h01);
        ind_enable <= 1'b1;
        t = 0;
        while (ind_on !== 1'b1 && t < 9000) begin
            @(posedge clk);
            t++;
        end
        meas = 12'h000;
        while (ind_on !== 1'b0 && t < 9000) begin
            @(posedge clk);
            meas++;
            t++;
        end
        hi_len = meas;
        while (ind_on !== 1'b1 && t < 9000) begin
            @(posedge clk);
            meas++;
            t++;
        end
        expect_out("active plus blank", 9, 12'd1728);
        // Lit for ramp up, hold and ramp down: 124 ms of 4-cycle ticks
        expect_out("lit time", 11, 12'd496);
        ind_external <= 1'b1;
        steady_pin <= 1'b1;
        settle(5);
        expect_out("pin follow high", 8, 12'h001);
        expect_out("pin level high", 10, 12'hFFF);
        steady_pin <= 1'b0;
        settle(5);
        expect_out("pin follow low", 8, 12'h000);
        expect_out("pin level low", 10, 12'h000);
        settle(2);
        results();
    end
endmodule
